// ===== logic/rcbc_consts.vh
// Constants for the range compare and BCD/binary conversion datapath.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef RCBC_CONSTS_VH
`define RCBC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RCBC_OFS_CTRL 8'h00
`define RCBC_OFS_OPA_LO 8'h04
`define RCBC_OFS_OPA_HI 8'h08
`define RCBC_OFS_LL_LO 8'h0C
`define RCBC_OFS_LL_HI 8'h10
`define RCBC_OFS_UL_LO 8'h14
`define RCBC_OFS_UL_HI 8'h18
`define RCBC_OFS_RES_LO 8'h1C
`define RCBC_OFS_RES_HI 8'h20
`define RCBC_OFS_STATUS 8'h24

// ****************************************************************
// Control register fields
// ****************************************************************
`define RCBC_CTRL_COND_BIT 0
`define RCBC_CTRL_OP_LSB 1
`define RCBC_CTRL_OP_MSB 3
`define RCBC_CTRL_IND_FAULT_BIT 4

// ****************************************************************
// Operation codes
// ****************************************************************
`define RCBC_OP_RANGE_CMP 3'h0
`define RCBC_OP_BCD_TO_BIN 3'h1
`define RCBC_OP_BIN_TO_BCD 3'h2
`define RCBC_OP_DBCD_TO_BIN 3'h3
`define RCBC_OP_DBIN_TO_BCD 3'h4

// ****************************************************************
// Status register fields
// ****************************************************************
`define RCBC_STAT_GR_BIT 0
`define RCBC_STAT_EQ_BIT 1
`define RCBC_STAT_LE_BIT 2
`define RCBC_STAT_ER_BIT 3

// ****************************************************************
// Conversion limits and reset values
// ****************************************************************
`define RCBC_BIN16_MAX 16'h270F
`define RCBC_BIN32_MAX 32'h05F5_E0FF
`define RCBC_RESET_WORD 16'h0000

`endif

// ===== logic/rcbc_datapath.v
// Range compare and BCD/binary conversion datapath with AHB-Lite registers.
// Assumes one clock, an asynchronous active-high reset and a single master.
//
// Behaviour
// - Double range compare treats value and limits as two-word 8-digit values.
// - Compare sets exactly one of less, equal, greater flags.
// - Error flag set when the lower limit exceeds the upper limit.
// - Error flag set on a faulty indirectly addressed memory word.
// - With execution condition false nothing changes.
// - BCD to binary writes the equal binary value to the result word.
// - BCD to binary flags an error on any non-decimal nibble.
// - All conversions set equal flag on zero result, clear otherwise.
// - Binary to BCD writes the four-digit decimal value to the result.
// - Binary to BCD above 270F does not execute; result kept.
// - Double BCD to binary converts eight digits into a 32-bit value.
// - Double BCD to binary flags error on a non-decimal nibble.
// - Double binary to BCD converts 32 bits into eight BCD digits.
// - Double binary to BCD above 05F5E0FF sets the error flag; results kept.
// - Double binary to BCD raises error when result exceeds 99999999.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rcbc_consts.vh"

module rcbc_datapath
(
    input wire clock,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output wire greater_flag,
    output wire equal_flag,
    output wire less_flag,
    output wire error_flag
);

    // ****************************************************************
    // Bus phase states
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_WRITE = 2'd1;
    localparam [1:0] ST_RD_WAIT = 2'd2;
    localparam [1:0] ST_RD_DONE = 2'd3;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // True when every nibble of the word is a decimal digit
    function bcd_ok;
        input [31:0] val;
        integer i;
        begin
            bcd_ok = 1'b1;
            for (i = 0; i < 8; i = i + 1)
            begin
                if (val[4*i +: 4] > 4'd9)
                begin
                    bcd_ok = 1'b0;
                end
            end
        end
    endfunction

    // Eight BCD digits to binary, most significant digit first
    function [31:0] bcd_to_bin;
        input [31:0] val;
        integer i;
        reg [31:0] acc;
        begin
            acc = 32'h0000_0000;
            for (i = 7; i >= 0; i = i - 1)
            begin
                acc = (acc << 3) + (acc << 1) + {28'h000_0000, val[4*i +: 4]};
            end
            bcd_to_bin = acc;
        end
    endfunction

    // Binary to eight BCD digits by shift and add three
    function [31:0] bin_to_bcd;
        input [31:0] val;
        integer i;
        integer j;
        reg [31:0] bcd;
        begin
            bcd = 32'h0000_0000;
            for (i = 31; i >= 0; i = i - 1)
            begin
                for (j = 0; j < 8; j = j + 1)
                begin
                    if (bcd[4*j +: 4] > 4'd4)
                    begin
                        bcd[4*j +: 4] = bcd[4*j +: 4] + 4'd3;
                    end
                end
                bcd = {bcd[30:0], val[i]};
            end
            bin_to_bcd = bcd;
        end
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [1:0] state_q;
    reg [7:0] addr_q;
    reg [4:0] ctrl_q;
    reg [15:0] opa_lo_q;
    reg [15:0] opa_hi_q;
    reg [15:0] ll_lo_q;
    reg [15:0] ll_hi_q;
    reg [15:0] ul_lo_q;
    reg [15:0] ul_hi_q;
    reg [15:0] res_lo_q;
    reg [15:0] res_hi_q;
    reg gr_q;
    reg eq_q;
    reg le_q;
    reg er_q;

    // ****************************************************************
    // Operand assembly
    // ****************************************************************

    wire [31:0] opa = {opa_hi_q, opa_lo_q};
    wire [31:0] ll = {ll_hi_q, ll_lo_q};
    wire [31:0] ul = {ul_hi_q, ul_lo_q};

    // Request decode for the address phase; control word decode for the data phase
    wire take = hsel & hready & htrans[1];
    wire exec = (state_q == ST_WRITE) && (addr_q == `RCBC_OFS_CTRL)
        && hwdata[`RCBC_CTRL_COND_BIT];
    wire [2:0] op = hwdata[`RCBC_CTRL_OP_MSB:`RCBC_CTRL_OP_LSB];
    wire ind_fault = hwdata[`RCBC_CTRL_IND_FAULT_BIT];

    // Conversion results
    wire [31:0] bin16 = bcd_to_bin({16'h0000, opa_lo_q});
    wire [31:0] bin32 = bcd_to_bin(opa);
    wire [31:0] bcd16 = bin_to_bcd({16'h0000, opa_lo_q});
    wire [31:0] bcd32 = bin_to_bcd(opa);

    // ****************************************************************
    // Bus outputs
    // ****************************************************************

    // Reads wait one cycle; writes and idle answer at once, always OKAY
    assign hreadyout = (state_q != ST_RD_WAIT);
    assign hresp = 1'b0;
    assign greater_flag = gr_q;
    assign equal_flag = eq_q;
    assign less_flag = le_q;
    assign error_flag = er_q;

    // Bus phase tracking
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            addr_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_RD_WAIT:
                begin
                    state_q <= ST_RD_DONE;
                end
                default:
                begin
                    if (take)
                    begin
                        addr_q <= {haddr[7:2], 2'b00};
                        state_q <= hwrite ? ST_WRITE : ST_RD_WAIT;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Read data, loaded during the wait cycle; unmapped reads give zero
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (state_q == ST_RD_WAIT)
        begin
            case (addr_q)
                `RCBC_OFS_CTRL: hrdata <= {27'h000_0000, ctrl_q};
                `RCBC_OFS_OPA_LO: hrdata <= {16'h0000, opa_lo_q};
                `RCBC_OFS_OPA_HI: hrdata <= {16'h0000, opa_hi_q};
                `RCBC_OFS_LL_LO: hrdata <= {16'h0000, ll_lo_q};
                `RCBC_OFS_LL_HI: hrdata <= {16'h0000, ll_hi_q};
                `RCBC_OFS_UL_LO: hrdata <= {16'h0000, ul_lo_q};
                `RCBC_OFS_UL_HI: hrdata <= {16'h0000, ul_hi_q};
                `RCBC_OFS_RES_LO: hrdata <= {16'h0000, res_lo_q};
                `RCBC_OFS_RES_HI: hrdata <= {16'h0000, res_hi_q};
                `RCBC_OFS_STATUS: hrdata <= {28'h000_0000, er_q, le_q, eq_q, gr_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Operand registers and control
    // ****************************************************************

    // Software writes to operand words; result and status are read only
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= 5'h00;
            opa_lo_q <= `RCBC_RESET_WORD;
            opa_hi_q <= `RCBC_RESET_WORD;
            ll_lo_q <= `RCBC_RESET_WORD;
            ll_hi_q <= `RCBC_RESET_WORD;
            ul_lo_q <= `RCBC_RESET_WORD;
            ul_hi_q <= `RCBC_RESET_WORD;
        end
        else if (state_q == ST_WRITE)
        begin
            case (addr_q)
                `RCBC_OFS_CTRL: ctrl_q <= hwdata[4:0];
                `RCBC_OFS_OPA_LO: opa_lo_q <= hwdata[15:0];
                `RCBC_OFS_OPA_HI: opa_hi_q <= hwdata[15:0];
                `RCBC_OFS_LL_LO: ll_lo_q <= hwdata[15:0];
                `RCBC_OFS_LL_HI: ll_hi_q <= hwdata[15:0];
                `RCBC_OFS_UL_LO: ul_lo_q <= hwdata[15:0];
                `RCBC_OFS_UL_HI: ul_hi_q <= hwdata[15:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // ****************************************************************
    // Instruction execution
    // ****************************************************************

    // Runs one instruction in the cycle the control word is written
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            res_lo_q <= `RCBC_RESET_WORD;
            res_hi_q <= `RCBC_RESET_WORD;
            gr_q <= 1'b0;
            eq_q <= 1'b0;
            le_q <= 1'b0;
            er_q <= 1'b0;
        end
        else if (exec)
        begin
            if (ind_fault)
            begin
                er_q <= 1'b1;
            end
            else
            begin
                case (op)
                    `RCBC_OP_RANGE_CMP:
                    begin
                        if (ll > ul)
                        begin
                            er_q <= 1'b1;
                        end
                        else
                        begin
                            er_q <= 1'b0;
                            le_q <= (opa < ll);
                            gr_q <= (opa > ul);
                            eq_q <= (opa >= ll) && (opa <= ul);
                        end
                    end
                    `RCBC_OP_BCD_TO_BIN:
                    begin
                        if (!bcd_ok({16'h0000, opa_lo_q}))
                        begin
                            er_q <= 1'b1;
                        end
                        else
                        begin
                            er_q <= 1'b0;
                            res_lo_q <= bin16[15:0];
                            eq_q <= (bin16 == 32'h0000_0000);
                        end
                    end
                    `RCBC_OP_BIN_TO_BCD:
                    begin
                        if (opa_lo_q <= `RCBC_BIN16_MAX)
                        begin
                            er_q <= 1'b0;
                            res_lo_q <= bcd16[15:0];
                            eq_q <= (bcd16 == 32'h0000_0000);
                        end
                    end
                    `RCBC_OP_DBCD_TO_BIN:
                    begin
                        if (!bcd_ok(opa))
                        begin
                            er_q <= 1'b1;
                        end
                        else
                        begin
                            er_q <= 1'b0;
                            res_lo_q <= bin32[15:0];
                            res_hi_q <= bin32[31:16];
                            eq_q <= (bin32 == 32'h0000_0000);
                        end
                    end
                    `RCBC_OP_DBIN_TO_BCD:
                    begin
                        if (opa > `RCBC_BIN32_MAX)
                        begin
                            er_q <= 1'b1;
                        end
                        else
                        begin
                            er_q <= 1'b0;
                            res_lo_q <= bcd32[15:0];
                            res_hi_q <= bcd32[31:16];
                            eq_q <= (bcd32 == 32'h0000_0000);
                        end
                    end
                    default:
                    begin
                        er_q <= er_q;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ===== testbench/rcbc_datapath_assertions.sv
// Concurrent checks on the datapath's bus answers and flag updates.
// Assumes binding to rcbc_datapath and a single AHB-Lite master.
`timescale 1ns/10ps
`default_nettype none
module rcbc_checker
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic greater_flag,
    input wire logic equal_flag,
    input wire logic less_flag,
    input wire logic error_flag
);
    // ****
    // Phase tracking
    // ****
    logic ctl_q, rd_q, ex_q, flt_q, cmp_q, cnv_q;
    wire logic take;
    wire logic fire;
    // Taken transfer and executing control write
    assign take = hsel && hready && htrans[1];
    assign fire = ctl_q && hready && hwdata[0];
    // Remembers control writes, reads and executions
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctl_q <= 1'b0;
            rd_q <= 1'b0;
            ex_q <= 1'b0;
            flt_q <= 1'b0;
            cmp_q <= 1'b0;
            cnv_q <= 1'b0;
        end
        else
        begin
            ctl_q <= take && hwrite && (haddr[7:2] == 6'h00);
            rd_q <= take && !hwrite;
            ex_q <= fire;
            flt_q <= fire && hwdata[4];
            cmp_q <= fire && !hwdata[4] && (hwdata[3:1] == 3'h0);
            cnv_q <= fire && !hwdata[4] && (hwdata[3:1] != 3'h0);
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    chk_ready_shape: // Read wait state
        assert property (rd_q |-> !hreadyout ##1 hreadyout) else $error("bad read wait");
    chk_resp_okay: // Response code
        assert property (hresp == 1'b0) else $error("response not okay");
    chk_rdata_hold: // Read data stands
        assert property (!$past(rd_q) |-> $stable(hrdata)) else $error("hrdata moved");
    chk_flags_hold:
        assert property (!ex_q |-> $stable({greater_flag, equal_flag, less_flag, error_flag}))
        else $error("flags moved without execution");
    chk_fault_err:
        assert property (flt_q |-> error_flag) else $error("fault did not set error");
    chk_fault_keep:
        assert property (flt_q |-> $stable({greater_flag, equal_flag, less_flag}))
        else $error("fault moved result flags");
    chk_cmp_onehot:
        assert property (cmp_q && !error_flag |-> $onehot({greater_flag, equal_flag, less_flag}))
        else $error("compare flags not one-hot");
    chk_conv_keep:
        assert property (cnv_q |-> $stable({greater_flag, less_flag}))
        else $error("conversion moved greater or less");
endmodule
bind rcbc_datapath rcbc_checker u_chk
(
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .greater_flag(greater_flag),
    .equal_flag(equal_flag), .less_flag(less_flag), .error_flag(error_flag)
);
`default_nettype wire

// ===== testbench/rcbc_datapath_tb.sv
// Self-checking bench for the range compare and conversion datapath.
// Assumes the design is the only slave of a bus driven by this bench.
`timescale 1ns/10ps
`default_nettype none
`include "rcbc_consts.vh"
module rcbc_datapath_tb;
    logic clock, rst, hsel, hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, eres, rd;
    logic [3:0] est;
    wire [31:0] hrdata;
    wire hreadyout, hresp, greater_flag, equal_flag, less_flag, error_flag;
    wire hready = hreadyout;
    int fail_count, n_tests;
    // Device under test
    rcbc_datapath u_rcbc_datapath (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .greater_flag(greater_flag),
        .equal_flag(equal_flag), .less_flag(less_flag), .error_flag(error_flag));
    // 10 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ****
    // Bus and check tasks
    // ****
    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // Ends on the rising edge where hready is seen high
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                fail_count++;
                report_and_stop();
            end
            @(negedge clock);
        end
        @(posedge clock);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr2(input logic [7:0] a, input logic [31:0] v);
        ahb(1'b1, a, {16'h0000, v[15:0]});
        ahb(1'b1, a + 8'h04, {16'h0000, v[31:16]});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        cmp(rd, e);
    endtask
    task automatic exec(input logic [2:0] op, input logic c, input logic f);
        ahb(1'b1, `RCBC_OFS_CTRL, {27'h000_0000, f, op, c});
    endtask
    // Flags by status register and by port
    task automatic chk_st();
        rchk(`RCBC_OFS_STATUS, {28'h000_0000, est});
        cmp({error_flag, less_flag, equal_flag, greater_flag}, {28'h000_0000, est});
    endtask
    task automatic do_cmp(input logic [31:0] v, input logic [3:0] e);
        wr2(`RCBC_OFS_OPA_LO, v);
        exec(`RCBC_OP_RANGE_CMP, 1'b1, 1'b0);
        est = e;
        chk_st();
    endtask
    // Mode 0 writes the result, 1 raises error, 2 changes nothing
    task automatic conv(input logic [2:0] op, input logic [31:0] s, input int m,
        input logic [31:0] r);
        wr2(`RCBC_OFS_OPA_LO, s);
        exec(op, 1'b1, 1'b0);
        if (m == 0)
        begin
            if (op < 3'h3)
                eres[15:0] = r[15:0];
            else
                eres = r;
            est = {1'b0, est[2], r == 32'h0000_0000, est[0]};
        end
        else if (m == 1)
            est[3] = 1'b1;
        rchk(`RCBC_OFS_RES_LO, {16'h0000, eres[15:0]});
        if (op > 3'h2)
            rchk(`RCBC_OFS_RES_HI, {16'h0000, eres[31:16]});
        chk_st();
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        chk_st();
        rchk(`RCBC_OFS_RES_LO, 32'h0000_0000);
        rchk(`RCBC_OFS_CTRL, 32'h0000_0000);
    endtask
    task automatic t_compare();
        wr2(`RCBC_OFS_LL_LO, 32'h0001_0000);
        wr2(`RCBC_OFS_UL_LO, 32'h0002_FFFF);
        do_cmp(32'h0000_FFFF, 4'h4);
        do_cmp(32'h0001_0000, 4'h2);
        do_cmp(32'h0002_FFFF, 4'h2);
        do_cmp(32'h0003_0000, 4'h1);
        wr2(`RCBC_OFS_OPA_LO, 32'h0000_0000);
        exec(`RCBC_OP_RANGE_CMP, 1'b0, 1'b0);
        chk_st();
        exec(`RCBC_OP_RANGE_CMP, 1'b1, 1'b1);
        est = 4'h9;
        chk_st();
        do_cmp(32'h0001_8000, 4'h2);
        wr2(`RCBC_OFS_LL_LO, 32'h0003_0000);
        exec(`RCBC_OP_RANGE_CMP, 1'b1, 1'b0);
        est = 4'hA;
        chk_st();
    endtask
    task automatic t_convert();
        conv(`RCBC_OP_BCD_TO_BIN, 32'h0005_9999, 0, 32'h0000_270F);
        conv(`RCBC_OP_BCD_TO_BIN, 32'h0000_0000, 0, 32'h0000_0000);
        conv(`RCBC_OP_BCD_TO_BIN, 32'h0000_12A4, 1, 32'h0000_0000);
        conv(`RCBC_OP_BIN_TO_BCD, 32'h0000_270F, 0, 32'h0000_9999);
        conv(`RCBC_OP_BIN_TO_BCD, 32'h0000_2710, 2, 32'h0000_0000);
        conv(`RCBC_OP_DBCD_TO_BIN, 32'h1234_5678, 0, 32'h00BC_614E);
        conv(`RCBC_OP_DBCD_TO_BIN, 32'h0A00_0000, 1, 32'h0000_0000);
        conv(`RCBC_OP_DBIN_TO_BCD, 32'h05F5_E0FF, 0, 32'h9999_9999);
        conv(`RCBC_OP_DBIN_TO_BCD, 32'h05F5_E100, 1, 32'h0000_0000);
        conv(`RCBC_OP_DBIN_TO_BCD, 32'h0000_0000, 0, 32'h0000_0000);
    endtask
    task automatic t_bus();
        rchk(`RCBC_OFS_CTRL, 32'h0000_0009);
        // Spare opcode executes as no operation
        exec(3'h5, 1'b1, 1'b0);
        chk_st();
        ahb(1'b1, `RCBC_OFS_RES_LO, 32'h0000_1234);
        rchk(`RCBC_OFS_RES_LO, {16'h0000, eres[15:0]});
        ahb(1'b1, 8'h3C, 32'h0000_5555);
        rchk(8'h3C, 32'h0000_0000);
    endtask
    // Reset in mid-run clears flags, results and control
    task automatic t_rerun();
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        est = 4'h0;
        @(posedge clock);
        t_reset();
    endtask
    // Main sequence
    initial
    begin
        fail_count = 0;
        n_tests = 0;
        est = 4'h0;
        eres = 32'h0000_0000;
        rd = 32'h0000_0000;
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_compare();
        t_convert();
        t_bus();
        t_rerun();
        report_and_stop();
    end
endmodule
`default_nettype wire
